// ---- dv/tb.sv ----
// self-checking bench for the transfer engine: record setup, activation, write-back
// assumes the bus model as data memory and the engine's own record store
`timescale 1ns/1ns
module tb
    import tdd_pkg::*;
;
    logic         clk_sys;
    logic         resetn;
    tdd_cpu_req_t cpu_i;
    logic         cpu_ack_ff;
    logic [7:0]   cpu_rdata_ff;
    logic         act_req;
    logic [4:0]   act_chan;
    logic         busy_ff;
    tdd_bus_t     dbus_ff;
    logic         dbus_ack;
    logic [7:0]   dbus_rdata;
    logic         irq_req_ff;
    logic [4:0]   irq_chan_ff;
    logic [1:0]   lat;
    int           error_cnt;
    int           n_compared;
    tdd_rec_t     rec [24];
    logic [23:0]  wr_q [$];
    logic [23:0]  rd_q [$];
    logic [23:0]  irq_q [$];

    tdd_engine tdd_engine_i (.clk_sys(clk_sys), .resetn(resetn), .cpu_i(cpu_i),
        .cpu_ack_ff(cpu_ack_ff), .cpu_rdata_ff(cpu_rdata_ff), .act_req(act_req),
        .act_chan(act_chan), .busy_ff(busy_ff), .dbus_ff(dbus_ff), .dbus_ack(dbus_ack),
        .dbus_rdata(dbus_rdata), .irq_req_ff(irq_req_ff), .irq_chan_ff(irq_chan_ff));
    tdd_bus_model tdd_bus_model_i (.clk_sys(clk_sys), .dbus(dbus_ff), .lat(lat),
        .ack_ff(dbus_ack), .rdata_ff(dbus_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cpu_acc(input logic we, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(negedge clk_sys);
        cpu_i = '{req: 1'b1, we: we, addr: a, wdata: d};
        for (i = 0; i < 50 && cpu_ack_ff !== 1'b1; i++) @(negedge clk_sys);
        check({23'h0, cpu_ack_ff}, 24'h1);
        cpu_i.req = 1'b0;
    endtask

    // software fills every byte and sets reload equal to count
    task automatic put_rec(input int r, input logic [7:0] c, input logic [7:0] b,
                           input logic [7:0] n);
        int k;
        rec[r] = '{dst: 16'($urandom), src: 16'($urandom), rld: n, cnt: n, blk: b, ctrl: c};
        for (k = 0; k < 8; k++) cpu_acc(1'b1, 8'(8 * r + k), rec[r][8 * k +: 8]);
    endtask

    task automatic read_rec(input int r);
        int k;
        for (k = 0; k < 8; k++) begin
            rd_q.push_back({16'h0, rec[r][8 * k +: 8]});
            cpu_acc(1'b0, 8'(8 * r + k), 8'h00);
        end
    endtask

    // reference of one activation, following chained records
    task automatic expect_run(input int r);
        tdd_rec_t x;
        int       n;
        int       rl;
        int       i;
        logic     rpt;
        logic     last;
        do begin
            x = rec[r];
            n = (x.blk == 8'h00) ? 256 : int'(x.blk);
            rpt = x.ctrl[0];
            for (i = 0; i < n; i++) begin
                wr_q.push_back({x.dst, x.src[7:0] ^ x.src[15:8] ^ 8'hA5});
                x.src = x.src + {15'h0, (rpt && x.ctrl[1]) || x.ctrl[2]};
                x.dst = x.dst + {15'h0, (rpt && !x.ctrl[1]) || x.ctrl[3]};
            end
            last = (x.cnt == 8'h01);
            x.cnt = x.cnt - 8'h01;
            if (last && (!rpt || x.ctrl[5])) irq_q.push_back({19'h0, 5'(r)});
            if (last && rpt) begin
                rl = (x.rld == 8'h00) ? 256 : int'(x.rld);
                x.cnt = x.rld;
                if (x.ctrl[1]) x.src = x.src - 16'(n * rl);
                else x.dst = x.dst - 16'(n * rl);
            end
            rec[r] = x;
            r++;
        end while (x.ctrl[4] && r <= 23);
    endtask

    task automatic run(input int ch);
        int i;
        expect_run(ch);
        @(negedge clk_sys);
        act_req  = 1'b1;
        act_chan = 5'(ch);
        for (i = 0; i < 20 && busy_ff !== 1'b1; i++) @(negedge clk_sys);
        act_req = 1'b0;
        for (i = 0; i < 5000 && busy_ff !== 1'b0; i++) @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
        check({23'h0, busy_ff}, 24'h0);
        check(24'(wr_q.size()), 24'h0);
        check(24'(irq_q.size()), 24'h0);
    endtask

    always @(negedge clk_sys) begin
        if (dbus_ack === 1'b1 && dbus_ff.req === 1'b1 && dbus_ff.we === 1'b1) begin
            check({dbus_ff.addr, dbus_ff.wdata}, wr_q.pop_front());
        end
        if (irq_req_ff === 1'b1) check({19'h0, irq_chan_ff}, irq_q.pop_front());
        if (cpu_ack_ff === 1'b1 && cpu_i.we === 1'b0) begin
            check({16'h0, cpu_rdata_ff}, rd_q.pop_front());
        end
    end

    initial begin
        #600000;
        error_cnt++;
        finish_test();
    end

    initial begin
        int k;
        void'($urandom(98316));
        error_cnt = 0;
        n_compared = 0;
        cpu_i = '0;
        act_req = 1'b0;
        act_chan = 5'h00;
        lat = 2'h0;
        resetn = 1'b0;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        rd_q.push_back(24'h0);
        cpu_acc(1'b0, 8'hC8, 8'h00);
        put_rec(0, 8'h2E, 8'h03, 8'h01);
        run(0);
        read_rec(0);
        put_rec(5, 8'h00, 8'h02, 8'h02);
        run(5);
        run(5);
        read_rec(5);
        lat = 2'h3;
        put_rec(7, 8'h25, 8'h02, 8'h01);
        run(7);
        read_rec(7);
        put_rec(8, 8'h0B, 8'h04, 8'h02);
        run(8);
        run(8);
        read_rec(8);
        lat = 2'h0;
        put_rec(9, 8'h04, 8'h00, 8'h00);
        run(9);
        read_rec(9);
        put_rec(22, 8'h1C, 8'h02, 8'h03);
        put_rec(23, 8'h0C, 8'h02, 8'h03);
        run(22);
        read_rec(22);
        read_rec(23);
        // a record number past the last one must leave the engine idle
        act_chan = 5'h18;
        act_req = 1'b1;
        for (k = 0; k < 20; k++) begin
            @(negedge clk_sys);
            check({23'h0, busy_ff}, 24'h0);
        end
        act_req = 1'b0;
        for (k = 0; k < 6; k++) begin
            lat = 2'($urandom);
            put_rec(10 + k, 8'($urandom) & 8'h2F, 8'(1 + $urandom % 6), 8'($urandom % 4));
            run(10 + k);
            read_rec(10 + k);
        end
        // second reset while the engine is idle; records survive it
        resetn = 1'b0;
        repeat (3) @(negedge clk_sys);
        resetn = 1'b1;
        check({22'h0, busy_ff, irq_req_ff}, 24'h0);
        run(0);
        read_rec(0);
        finish_test();
    end
endmodule // tb

// ---- dv/tdd_bus_model.sv ----
// data bus partner: byte memory whose read data is a fixed function of the address
// assumes the engine holds each request until ack and alternates read and write
`timescale 1ns/1ns
module tdd_bus_model
    import tdd_pkg::*;
(
    // clock
    input  wire logic       clk_sys,
    // bus from the engine, with its wait-state setting lat
    input  wire tdd_bus_t   dbus,
    input  wire logic [1:0] lat,
    output logic            ack_ff,
    output logic [7:0]      rdata_ff
);
    logic [1:0] wait_ff;

    initial begin
        ack_ff   = 1'b0;
        rdata_ff = 8'h00;
        wait_ff  = 2'h0;
    end

    always @(posedge clk_sys) begin
        ack_ff   <= 1'b0;
        // read data only means something with ack, so it is scrambled otherwise
        rdata_ff <= ~rdata_ff;
        if (dbus.req && !ack_ff) begin
            if (wait_ff == lat) begin
                ack_ff  <= 1'b1;
                wait_ff <= 2'h0;
                if (!dbus.we) rdata_ff <= dbus.addr[7:0] ^ dbus.addr[15:8] ^ 8'hA5;
            end else begin
                wait_ff <= wait_ff + 2'h1;
            end
        end
    end
endmodule // tdd_bus_model

// ---- include/tdd_params.svh ----
// transfer descriptor decode: record layout, field positions, sizes
// assumes inclusion from the engine file by bare name
`ifndef TDD_PARAMS_SVH
`define TDD_PARAMS_SVH

`define TDD_REC_NUM      24
`define TDD_REC_BYTES    8
`define TDD_AREA_BYTES   192
`define TDD_LAST_REC     5'h17

// byte offsets inside one record
`define TDD_OFF_CTRL     3'h0
`define TDD_OFF_BLK      3'h1
`define TDD_OFF_CNT      3'h2
`define TDD_OFF_RLD      3'h3
`define TDD_OFF_SRC_LO   3'h4
`define TDD_OFF_SRC_HI   3'h5
`define TDD_OFF_DST_LO   3'h6
`define TDD_OFF_DST_HI   3'h7

// bit positions in the transfer control byte
`define TDD_BIT_MODE     0
`define TDD_BIT_RPTSIDE  1
`define TDD_BIT_SRCSTEP  2
`define TDD_BIT_DSTSTEP  3
`define TDD_BIT_CHAIN    4
`define TDD_BIT_RPTIRQ   5

// zero in an 8-bit size or count field stands for this many
`define TDD_FULL_COUNT   9'h100

`endif

// ---- include/tdd_pkg.sv ----
// transfer descriptor decode: shared types
// assumes tdd_params.svh on the include path
package tdd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_RD,
        ST_WR,
        ST_UPD,
        ST_WB
    } tdd_state_t;

    // byte 0 in the low bits, record byte k at bits 8k+7..8k
    typedef struct packed {
        logic [15:0] dst;
        logic [15:0] src;
        logic [7:0]  rld;
        logic [7:0]  cnt;
        logic [7:0]  blk;
        logic [7:0]  ctrl;
    } tdd_rec_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } tdd_cpu_req_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } tdd_bus_t;

endpackage

// ---- logic/tdd_engine.sv ----
// transfer descriptor decode: record fetch, byte mover, record update
// assumes activation requests held until busy rises, a bus that acks
`timescale 1ns/1ns
`include "tdd_params.svh"
module tdd_engine
    import tdd_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // processor access to the record area
    input  wire tdd_cpu_req_t cpu_i,
    output logic              cpu_ack_ff,
    output logic [7:0]        cpu_rdata_ff,
    // activation
    input  wire logic         act_req,
    input  wire logic [4:0]   act_chan,
    output logic              busy_ff,
    // data bus
    output tdd_bus_t          dbus_ff,
    input  wire logic         dbus_ack,
    input  wire logic [7:0]   dbus_rdata,
    // completion interrupt toward the processor
    output logic              irq_req_ff,
    output logic [4:0]        irq_chan_ff
);
    tdd_state_t  state_ff, nxt_state;
    logic [3:0]  idx_ff;
    logic [4:0]  chan_ff;
    logic [63:0] wk_ff;
    logic [8:0]  left_ff;
    logic        exp_ff;
    logic        cpu_tk_ff;
    tdd_rec_t    rec, wk_step, wk_upd;
    logic [7:0]  mem_rdata;

    assign rec = tdd_rec_t'(wk_ff);

    // decoded control bits
    wire mode_rpt  = rec.ctrl[`TDD_BIT_MODE];
    wire rpt_src   = mode_rpt && rec.ctrl[`TDD_BIT_RPTSIDE];
    wire rpt_dst   = mode_rpt && !rec.ctrl[`TDD_BIT_RPTSIDE];
    wire inc_src   = rpt_src || (!rpt_src && rec.ctrl[`TDD_BIT_SRCSTEP]);
    wire inc_dst   = rpt_dst || (!rpt_dst && rec.ctrl[`TDD_BIT_DSTSTEP]);
    wire chain_on  = rec.ctrl[`TDD_BIT_CHAIN] && (chan_ff != `TDD_LAST_REC);
    wire irq_on    = !mode_rpt || rec.ctrl[`TDD_BIT_RPTIRQ];

    // zero means a full 256
    wire [8:0]  blk_eff = (rec.blk == 8'h00) ? `TDD_FULL_COUNT : {1'b0, rec.blk};
    wire [8:0]  rld_eff = (rec.rld == 8'h00) ? `TDD_FULL_COUNT : {1'b0, rec.rld};
    wire [17:0] span    = blk_eff * rld_eff;
    wire        expire  = (rec.cnt == 8'h01);

    wire act_go     = (state_ff == ST_IDLE) && act_req && (act_chan <= `TDD_LAST_REC);
    wire cpu_take   = (state_ff == ST_IDLE) && cpu_i.req && !act_go && !cpu_tk_ff && !cpu_ack_ff;
    wire fetch_done = (state_ff == ST_FETCH) && (idx_ff == 4'h8);
    wire wb_last    = (state_ff == ST_WB) && (idx_ff == 4'h7);
    wire wr_done    = (state_ff == ST_WR) && dbus_ack;
    wire more_bytes = (left_ff != 9'h001);

    // record store port: engine owns it while fetching or writing back
    wire [2:0] eng_byte = idx_ff[2:0];
    wire       eng_own  = (state_ff == ST_FETCH) || (state_ff == ST_WB);
    wire [7:0] mem_addr = eng_own ? {chan_ff, eng_byte} : cpu_i.addr;
    wire       mem_we   = (state_ff == ST_WB) || (cpu_take && cpu_i.we);
    wire [7:0] mem_wd   = (state_ff == ST_WB) ? wk_ff[{eng_byte, 3'b000} +: 8] : cpu_i.wdata;

    tdd_rec_mem #(
        .DEPTH (`TDD_AREA_BYTES),
        .AW    (8)
    ) u_mem (
        .clk_sys  (clk_sys),
        .we       (mem_we),
        .addr     (mem_addr),
        .wdata    (mem_wd),
        .rdata_ff (mem_rdata)
    );

    // per-byte pointer step and per-activation count update
    always_comb begin
        wk_step = rec;
        wk_step.src = rec.src + {15'h0000, inc_src};
        wk_step.dst = rec.dst + {15'h0000, inc_dst};
        wk_upd = rec;
        wk_upd.cnt = rec.cnt - 8'h01;
        if (expire && mode_rpt) begin
            wk_upd.cnt = rec.rld;
            if (rpt_src) begin
                wk_upd.src = rec.src - span[15:0];
            end else begin
                wk_upd.dst = rec.dst - span[15:0];
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:  if (act_go) nxt_state = ST_FETCH;
            ST_FETCH: if (fetch_done) nxt_state = ST_RD;
            ST_RD:    if (dbus_ack) nxt_state = ST_WR;
            ST_WR:    if (wr_done) nxt_state = more_bytes ? ST_RD : ST_UPD;
            ST_UPD:   nxt_state = ST_WB;
            ST_WB:    if (wb_last) nxt_state = chain_on ? ST_FETCH : ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != ST_IDLE);
        end
    end

    // byte counter for fetch and write-back, channel number
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            idx_ff  <= 4'h0;
            chan_ff <= 5'h00;
        end else begin
            if (act_go) begin
                chan_ff <= act_chan;
            end else if (wb_last && chain_on) begin
                chan_ff <= chan_ff + 5'h01;
            end
            idx_ff <= eng_own && !fetch_done && !wb_last ? idx_ff + 4'h1 : 4'h0;
        end
    end

    // working copy of the record; read data trails the address by one
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wk_ff   <= 64'h0;
            left_ff <= 9'h000;
            exp_ff  <= 1'b0;
        end else begin
            if (state_ff == ST_FETCH && idx_ff != 4'h0) begin
                wk_ff[{eng_byte - 3'h1, 3'b000} +: 8] <= mem_rdata;
            end else if (wr_done) begin
                wk_ff <= wk_step;
            end else if (state_ff == ST_UPD) begin
                wk_ff <= wk_upd;
            end
            if (state_ff == ST_RD && $past(state_ff) == ST_FETCH) begin
                left_ff <= blk_eff;
            end else if (wr_done) begin
                left_ff <= left_ff - 9'h001;
            end
            if (state_ff == ST_UPD) begin
                exp_ff <= expire;
            end
        end
    end

    // data bus request, held until acknowledged
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dbus_ff <= '0;
        end else if (fetch_done) begin
            dbus_ff <= '{req: 1'b1, we: 1'b0, addr: rec.src, wdata: 8'h00};
        end else if (state_ff == ST_RD && dbus_ack) begin
            dbus_ff <= '{req: 1'b1, we: 1'b1, addr: rec.dst, wdata: dbus_rdata};
        end else if (wr_done) begin
            dbus_ff <= '{req: more_bytes, we: 1'b0, addr: wk_step.src, wdata: 8'h00};
        end
    end

    // the last record byte is captured on the same edge the first read leaves: the
    // source address above is taken from the record as it stands after byte 6
    // completion interrupt, one cycle after the last write-back byte
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irq_req_ff  <= 1'b0;
            irq_chan_ff <= 5'h00;
        end else begin
            irq_req_ff <= wb_last && exp_ff && irq_on;
            if (wb_last) begin
                irq_chan_ff <= chan_ff;
            end
        end
    end

    // processor access: ack two cycles after the request is taken
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cpu_tk_ff    <= 1'b0;
            cpu_ack_ff   <= 1'b0;
            cpu_rdata_ff <= 8'h00;
        end else begin
            cpu_tk_ff  <= cpu_take;
            cpu_ack_ff <= cpu_tk_ff;
            if (cpu_tk_ff) begin
                cpu_rdata_ff <= mem_rdata;
            end
        end
    end

    // checks
    property p_blk_size;
        @(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_RD && $past(state_ff) == ST_FETCH) |=>
            left_ff == ((rec.blk == 8'h00) ? 9'h100 : {1'b0, rec.blk});
    endproperty
    a_blk_size: assert property (p_blk_size) else $error("block size load wrong");

    property p_cnt_dec;
        @(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_UPD && !(expire && mode_rpt)) |=> rec.cnt == $past(rec.cnt) - 8'h01;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) else $error("count not decremented");

    property p_reload;
        @(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_UPD && expire && mode_rpt) |=> rec.cnt == $past(rec.rld);
    endproperty
    a_reload: assert property (p_reload) else $error("count not reloaded");

    property p_src_fixed;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_done && !mode_rpt && !rec.ctrl[`TDD_BIT_SRCSTEP]) |=> rec.src == $past(rec.src);
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("fixed source moved");

    property p_dst_inc;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_done && !mode_rpt && rec.ctrl[`TDD_BIT_DSTSTEP]) |=>
            rec.dst == $past(rec.dst) + 16'h0001;
    endproperty
    a_dst_inc: assert property (p_dst_inc) else $error("destination not stepped");

    property p_rpt_side;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_done && rpt_src && !rec.ctrl[`TDD_BIT_SRCSTEP]) |=>
            rec.src == $past(rec.src) + 16'h0001;
    endproperty
    a_rpt_side: assert property (p_rpt_side) else $error("repeat side step wrong");

    property p_restore;
        @(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_UPD && expire && rpt_dst) |=> rec.dst == $past(rec.dst) - $past(span[15:0]);
    endproperty
    a_restore: assert property (p_restore) else $error("repeat address not restored");

    property p_irq;
        @(posedge clk_sys) disable iff (!resetn)
        (wb_last && exp_ff && !mode_rpt) |=> irq_req_ff && irq_chan_ff == $past(chan_ff);
    endproperty
    a_irq: assert property (p_irq) else $error("normal expiry gave no interrupt");

    property p_no_rpt_irq;
        @(posedge clk_sys) disable iff (!resetn)
        (wb_last && mode_rpt && !rec.ctrl[`TDD_BIT_RPTIRQ]) |=> !irq_req_ff;
    endproperty
    a_no_rpt_irq: assert property (p_no_rpt_irq) else $error("masked repeat interrupt");

    property p_fetch_first;
        @(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_IDLE ##1 state_ff != ST_IDLE) |-> state_ff == ST_FETCH && !dbus_ff.req;
    endproperty
    a_fetch_first: assert property (p_fetch_first) else $error("data moved before fetch");

    property p_writeback;
        @(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_UPD) |=> (state_ff == ST_WB)[*8];
    endproperty
    a_writeback: assert property (p_writeback) else $error("write-back cut short");

    property p_chain;
        @(posedge clk_sys) disable iff (!resetn)
        (wb_last && chain_on) |=> state_ff == ST_FETCH && chan_ff == $past(chan_ff) + 5'h01;
    endproperty
    a_chain: assert property (p_chain) else $error("chain not followed");

    c_chain:  cover property (@(posedge clk_sys) wb_last && chain_on);
    c_reload: cover property (@(posedge clk_sys) state_ff == ST_UPD && expire && mode_rpt);
    c_blk256: cover property (@(posedge clk_sys) fetch_done ##1 rec.blk == 8'h00);
    c_irq:    cover property (@(posedge clk_sys) irq_req_ff);
endmodule // tdd_engine

// ---- logic/tdd_rec_mem.sv ----
// transfer descriptor decode: control record store, one port
// assumes one access per cycle, read data one cycle after the address
`timescale 1ns/1ns
module tdd_rec_mem #(
    parameter int DEPTH = `TDD_AREA_BYTES,
    parameter int AW    = 8
) (
    // clock
    input  wire logic          clk_sys,
    // port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata_ff
);
    // contents undefined after reset, as the records are
    logic [7:0] mem [DEPTH];
    wire        in_range = (32'(addr) < DEPTH);

    always_ff @(posedge clk_sys) begin
        if (we && in_range) begin
            mem[addr] <= wdata;
        end
        rdata_ff <= in_range ? mem[addr] : 8'h00;
    end
endmodule // tdd_rec_mem
